// ==== hdl/ascp_pkg.sv ====
package ascp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_HZ      = 25_000_000;
	localparam int unsigned TIMEOUT_S   = 15;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;

	////////////////////////////////////////////////////////////////////////////////
	// line and field limits
	localparam int unsigned LINE_LEN_DEF = 56;
	localparam int unsigned LINE_MIN     = 54;
	localparam int unsigned PW_MAX       = 16;
	localparam int unsigned INFO_MAX     = 16;
	localparam logic [2:0]  CH_FIELDS    = 3'h6;
	localparam logic [2:0]  CO_FIELDS    = 3'h5;
	localparam logic [19:0] PORT_MIN     = 20'h00400;
	localparam logic [19:0] PORT_MAX     = 20'h0FFFF;
	localparam logic [15:0] PORT_RST     = 16'h2711;

	////////////////////////////////////////////////////////////////////////////////
	// characters and command names
	localparam logic [7:0]  CH_DOLLAR = 8'h24;
	localparam logic [7:0]  CH_CR     = 8'h0D;
	localparam logic [7:0]  CH_LF     = 8'h0A;
	localparam logic [7:0]  CH_QM     = 8'h3F;
	localparam logic [7:0]  CH_COMMA  = 8'h2C;
	localparam logic [7:0]  CH_COLON  = 8'h3A;
	localparam logic [7:0]  CH_ZERO   = 8'h30;
	localparam logic [23:0] CMD_LINK  = 24'h494643;
	localparam logic [23:0] CMD_DPQ   = 24'h474450;
	localparam logic [23:0] CMD_DPS   = 24'h534450;
	localparam logic [23:0] CMD_CHAN  = 24'h434849;
	localparam logic [23:0] CMD_CTRL  = 24'h434F49;
	localparam logic [23:0] CMD_LOGIN = 24'h4C4749;
	localparam logic [23:0] CMD_LOGO  = 24'h4C474F;
	localparam logic [23:0] CMD_PWCH  = 24'h505744;
	localparam logic [23:0] CMD_LANG  = 24'h4C4E47;

	////////////////////////////////////////////////////////////////////////////////
	// reply texts, right aligned
	localparam logic [127:0] MSG_OK      = "OK";
	localparam logic [127:0] MSG_UNKNOWN = "$UNKNOWN COMMAND";
	localparam logic [127:0] MSG_PARAM   = "$WRONG PARAMETER";
	localparam logic [127:0] MSG_TIMEOUT = "$TIMEOUT";
	localparam logic [127:0] MSG_PASSWD  = "$WRONG PASSWORD";
	localparam logic [6:0]   LEN_OK      = 7'h02;
	localparam logic [6:0]   LEN_UNKNOWN = 7'h10;
	localparam logic [6:0]   LEN_PARAM   = 7'h10;
	localparam logic [6:0]   LEN_TIMEOUT = 7'h08;
	localparam logic [6:0]   LEN_PASSWD  = 7'h0F;

	////////////////////////////////////////////////////////////////////////////////
	// register map and fields
	localparam logic [5:0] REG_CONFIG   = 6'h00;
	localparam logic [5:0] REG_STATUS   = 6'h01;
	localparam logic [5:0] REG_IRQ_STAT = 6'h02;
	localparam logic [5:0] REG_IRQ_MASK = 6'h03;
	localparam int unsigned STS_LINK_SEL = 0;
	localparam int unsigned STS_LINK_ACT = 1;
	localparam int unsigned STS_PRO      = 2;
	localparam int unsigned STS_LANG     = 3;
	localparam int unsigned STS_SEL_AUTO = 5;
	localparam int unsigned STS_BUSY     = 6;
	localparam int unsigned EV_OK        = 0;
	localparam int unsigned EV_ERR       = 1;
	localparam int unsigned EV_TIMEOUT   = 2;
	localparam int unsigned EV_BADPW     = 3;
	localparam int unsigned EV_W         = 4;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [2:0] {SUF_OK, SUF_UNKNOWN, SUF_PARAM, SUF_TIMEOUT, SUF_PASSWD} ascp_suf_e;
	typedef enum logic [1:0] {PAY_NONE, PAY_DIGIT, PAY_PORT, PAY_INFO} ascp_pay_e;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ascp_wb_req_s;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} ascp_wb_rsp_s;

endpackage : ascp_pkg

// ==== hdl/ascp_parser.sv ====
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
// How it works
// - link choice counts only in auto position
// - stored link choice activates after restart
// - link code 0 ethernet, 1 fieldbus, query
// - port query replies with current data port
// - port set accepts 1024 through 65535 only
// - channel info index 1-4, seven fields
// - value type 1 integer, 0 none
// - controller info five fields, comma separated
// - correct login password raises professional level
// - logout drops to user level, echo OK
// - factory password is empty
// - new password twice, 0-16 alphanumerics
// - language code 0, 1 or 2
// - unknown name: echo plus unknown error
// - bad argument: echo plus parameter error
// - 15 s idle input: echo plus timeout
module ascp_parser #(
	parameter int unsigned LINE_LEN       = ascp_pkg::LINE_LEN_DEF,
	parameter int unsigned TIMEOUT_CYCLES = ascp_pkg::TIMEOUT_CYC
) (
	input  wire logic                  clk_sys,
	input  wire logic                  srst,
	input  wire ascp_pkg::ascp_wb_req_s wb_req,
	output ascp_pkg::ascp_wb_rsp_s     wb_rsp,
	input  wire logic [7:0]            rx_data,
	input  wire logic                  rx_valid,
	output logic                       rx_ready,
	output logic [7:0]                 tx_data,
	output logic                       tx_valid,
	input  wire logic                  tx_ready,
	input  wire logic                  selector_auto_position,
	input  wire logic                  link_nv,
	output logic                       link_store,
	output logic                       link_active,
	output logic [15:0]                data_port,
	output logic                       access_pro,
	output logic [1:0]                 web_language,
	input  wire logic [3:0]            chan_present,
	output logic [2:0]                 info_target,
	output logic [2:0]                 info_field,
	output logic [3:0]                 info_index,
	input  wire logic [7:0]            info_char,
	output logic                       irq
);
	import ascp_pkg::*;

	localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYCLES - 1);

	if (LINE_LEN < LINE_MIN || LINE_LEN > 64 || TIMEOUT_CYCLES < 2) begin : g_bad_param
		$error("ascp_parser: line length or timeout out of range");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_EVAL, ST_SEND} ascp_st_e;
	typedef enum logic [2:0] {PH_ECHO, PH_PAY, PH_SUF, PH_CR, PH_LF} ascp_ph_e;

	function automatic logic is_digit(input logic [7:0] c);
		return c >= 8'h30 && c <= 8'h39;
	endfunction : is_digit

	function automatic logic is_alnum(input logic [7:0] c);
		return is_digit(c) || (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A);
	endfunction : is_alnum

	function automatic logic [15:0] pow10(input logic [2:0] k);
		unique case (k)
			3'h0:    return 16'h2710;
			3'h1:    return 16'h03E8;
			3'h2:    return 16'h0064;
			3'h3:    return 16'h000A;
			default: return 16'h0001;
		endcase
	endfunction : pow10

	function automatic logic [7:0] msg_char(input ascp_suf_e s, input logic [6:0] i);
		logic [127:0] t;
		logic [6:0]   l;
		unique case (s)
			SUF_OK:      begin t = MSG_OK;      l = LEN_OK;      end
			SUF_UNKNOWN: begin t = MSG_UNKNOWN; l = LEN_UNKNOWN; end
			SUF_PARAM:   begin t = MSG_PARAM;   l = LEN_PARAM;   end
			SUF_TIMEOUT: begin t = MSG_TIMEOUT; l = LEN_TIMEOUT; end
			default:     begin t = MSG_PASSWD;  l = LEN_PASSWD;  end
		endcase
		return t[8*(l-7'd1-i) +: 8];
	endfunction : msg_char

	function automatic logic [6:0] msg_len(input ascp_suf_e s);
		unique case (s)
			SUF_OK:      return LEN_OK;
			SUF_UNKNOWN: return LEN_UNKNOWN;
			SUF_PARAM:   return LEN_PARAM;
			SUF_TIMEOUT: return LEN_TIMEOUT;
			default:     return LEN_PASSWD;
		endcase
	endfunction : msg_len

	////////////////////////////////////////////////////////////////////////////////
	// state
	ascp_st_e        st_q, st_d;
	ascp_ph_e        ph_q, ph_d;
	ascp_suf_e       suf_q, suf_d;
	ascp_pay_e       pay_q, pay_d;
	logic [7:0]      buf_q [LINE_LEN];
	logic [7:0]      buf_d [LINE_LEN];
	logic [6:0]      len_q, len_d, idx_q, idx_d;
	logic            ovf_q, ovf_d, echo_q, echo_d, pre_v_q, pre_v_d;
	logic [TW-1:0]   tmo_q, tmo_d;
	logic [7:0]      digit_q, digit_d, pre_q, pre_d, tx_data_q, tx_data_d;
	logic [2:0]      tgt_q, tgt_d, fld_q, fld_d;
	logic            tx_valid_q, tx_valid_d;
	logic [15:0]     port_q, port_d;
	logic            link_sel_q, link_sel_d, link_boot_q, link_boot_d, boot_q, boot_d;
	logic            link_act_q, link_act_d, pro_q, pro_d;
	logic [1:0]      lang_q, lang_d;
	logic [7:0]      pw_q [PW_MAX];
	logic [7:0]      pw_d [PW_MAX];
	logic [4:0]      pw_len_q, pw_len_d;
	logic [EV_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
	logic            ack_q, ack_d;
	logic [31:0]     rdat_q, rdat_d;
	logic            sel_s1_q, sel_s2_q;

	////////////////////////////////////////////////////////////////////////////////
	// line parsing
	logic [23:0] cmd;
	logic [6:0]  arg_len, c1, c2, old_len, n1_len, n2_len, j1, j2;
	logic [7:0]  arg0, ch1, ch2;
	logic [19:0] num;
	logic        num_bad, have1, have2, extra, pre_eq, new_same, new_alnum;
	logic        port_ok, lgi_ok, old_ok, new_ok;
	logic [7:0]  new_pw [PW_MAX];
	logic [3:0]  port_dig;
	logic [19:0] wport;

	always_comb begin
		cmd       = {buf_q[1], buf_q[2], buf_q[3]};
		arg_len   = (len_q > 7'h04) ? 7'(len_q - 7'h04) : 7'h00;
		arg0      = buf_q[4];
		num       = 20'h00000;
		num_bad   = 1'b0;
		{c1, c2}  = 14'h0000;
		{have1, have2, extra} = 3'h0;
		{pre_eq, new_same, new_alnum} = 3'h7;
		{j1, j2}  = 14'h0000;
		{ch1, ch2} = 16'h0000;
		new_pw    = '{default: 8'h00};
		for (int i = 0; i < 6; i++) begin
			if (7'(i) < arg_len) begin
				if (is_digit(buf_q[4+i]))
					num = 20'(num * 20'h0000A + 20'(buf_q[4+i] - CH_ZERO));
				else
					num_bad = 1'b1;
			end
		end
		for (int i = 4; i < LINE_LEN; i++) begin
			if (7'(i) < len_q && buf_q[i] == CH_COMMA) begin
				if (!have1) begin
					c1    = 7'(i);
					have1 = 1'b1;
				end else if (!have2) begin
					c2    = 7'(i);
					have2 = 1'b1;
				end else begin
					extra = 1'b1;
				end
			end
		end
		old_len = 7'(c1 - 7'h04);
		n1_len  = 7'(c2 - c1 - 7'h01);
		n2_len  = 7'(len_q - c2 - 7'h01);
		for (int i = 0; i < PW_MAX; i++) begin
			j1  = 7'(c1 + 7'(i) + 7'h01);
			j2  = 7'(c2 + 7'(i) + 7'h01);
			ch1 = (j1 < 7'(LINE_LEN)) ? buf_q[j1[5:0]] : 8'h00;
			ch2 = (j2 < 7'(LINE_LEN)) ? buf_q[j2[5:0]] : 8'h00;
			if (7'(i) < n1_len) begin
				new_same  = new_same && ch1 == ch2;
				new_alnum = new_alnum && is_alnum(ch1);
				new_pw[i] = ch1;
			end
			if (5'(i) < pw_len_q && buf_q[4+i] != pw_q[i])
				pre_eq = 1'b0;
		end
		port_ok  = !num_bad && arg_len != 7'h00 && arg_len < 7'h06
			&& num >= PORT_MIN && num <= PORT_MAX;
		lgi_ok   = arg_len == 7'(pw_len_q) && pre_eq;
		old_ok   = old_len == 7'(pw_len_q) && pre_eq;
		new_ok   = have2 && !extra && n1_len == n2_len && n1_len <= 7'(PW_MAX)
			&& new_same && new_alnum;
		port_dig = 4'((port_q / pow10(idx_q[2:0])) % 16'h000A);
	end

	////////////////////////////////////////////////////////////////////////////////
	// engine and register bus
	always_comb begin
		st_d = st_q; ph_d = ph_q; suf_d = suf_q; pay_d = pay_q;
		buf_d = buf_q; len_d = len_q; ovf_d = ovf_q; tmo_d = tmo_q;
		idx_d = idx_q; echo_d = echo_q; digit_d = digit_q;
		pre_d = pre_q; pre_v_d = pre_v_q; tgt_d = tgt_q; fld_d = fld_q;
		tx_data_d = tx_data_q;
		tx_valid_d = tx_valid_q && !tx_ready;
		port_d = port_q; link_sel_d = link_sel_q; link_boot_d = link_boot_q; boot_d = 1'b1;
		lang_d = lang_q; pro_d = pro_q; pw_d = pw_q; pw_len_d = pw_len_q;
		ev = '0;
		imask_d = imask_q;
		ack_d = wb_req.cyc && wb_req.stb && !ack_q;
		rdat_d = 32'h00000000;
		wport = {4'h0, wb_req.sel[1] ? wb_req.dat[15:8] : port_q[15:8],
			wb_req.sel[0] ? wb_req.dat[7:0] : port_q[7:0]};
		if (!boot_q) begin
			link_sel_d  = link_nv;
			link_boot_d = link_nv;
		end
		link_act_d = link_boot_q && sel_s2_q;
		unique case (st_q)
			ST_IDLE: begin
				if (rx_valid && !tx_valid_q && rx_data == CH_DOLLAR) begin
					buf_d[0] = rx_data;
					len_d    = 7'h01;
					ovf_d    = 1'b0;
					tmo_d    = '0;
					st_d     = ST_RECV;
				end
			end
			ST_RECV: begin
				if (rx_valid) begin
					tmo_d = '0;
					if (rx_data == CH_CR) begin
						st_d = ST_EVAL;
					end else if (len_q < 7'(LINE_LEN)) begin
						buf_d[len_q[5:0]] = rx_data;
						len_d = 7'(len_q + 7'h01);
					end else begin
						ovf_d = 1'b1;
					end
				end else if (tmo_q == TMO_LAST) begin
					echo_d = 1'b1; suf_d = SUF_TIMEOUT; pay_d = PAY_NONE;
					ph_d = PH_ECHO; idx_d = 7'h00; st_d = ST_SEND;
					ev[EV_TIMEOUT] = 1'b1;
				end else begin
					tmo_d = TW'(tmo_q + 1'b1);
				end
			end
			ST_EVAL: begin
				suf_d = SUF_OK; pay_d = PAY_NONE; pre_v_d = 1'b0; pre_d = CH_COMMA;
				tgt_d = 3'h0; fld_d = 3'h0; idx_d = 7'h00; ph_d = PH_ECHO; st_d = ST_SEND;
				if (len_q < 7'h04) suf_d = SUF_UNKNOWN;
				else unique case (cmd)
					CMD_LINK: begin
						if (arg_len == 7'h01 && arg0 == CH_QM) begin
							pay_d = PAY_DIGIT; digit_d = 8'(CH_ZERO + 8'(link_sel_q));
						end else if (arg_len == 7'h01 && (arg0 == 8'h30 || arg0 == 8'h31))
							link_sel_d = arg0[0];
						else suf_d = SUF_PARAM;
					end
					CMD_DPQ: if (arg_len == 7'h00) pay_d = PAY_PORT; else suf_d = SUF_PARAM;
					CMD_DPS: if (port_ok) port_d = num[15:0]; else suf_d = SUF_PARAM;
					CMD_CHAN: begin
						if (arg_len == 7'h01 && arg0 >= 8'h31 && arg0 <= 8'h34) begin
							pay_d = PAY_INFO; tgt_d = arg0[2:0]; pre_d = CH_COLON; pre_v_d = 1'b1;
						end else suf_d = SUF_PARAM;
					end
					CMD_CTRL: if (arg_len == 7'h00) pay_d = PAY_INFO; else suf_d = SUF_PARAM;
					CMD_LOGIN: begin
						if (arg_len > 7'(PW_MAX)) suf_d = SUF_PARAM;
						else if (lgi_ok) pro_d = 1'b1;
						else suf_d = SUF_PASSWD;
					end
					CMD_LOGO: if (arg_len == 7'h00) pro_d = 1'b0; else suf_d = SUF_PARAM;
					CMD_PWCH: begin
						if (!new_ok) suf_d = SUF_PARAM;
						else if (!old_ok) suf_d = SUF_PASSWD;
						else begin
							pw_d = new_pw; pw_len_d = n1_len[4:0];
						end
					end
					CMD_LANG: begin
						if (arg_len == 7'h01 && arg0 >= 8'h30 && arg0 <= 8'h32) lang_d = arg0[1:0];
						else suf_d = SUF_PARAM;
					end
					default: suf_d = SUF_UNKNOWN;
				endcase
				// overlong line that would reply OK is a bad argument
				if (ovf_q && suf_d == SUF_OK) begin
					suf_d = SUF_PARAM; pay_d = PAY_NONE;
					{pro_d, lang_d, port_d, link_sel_d} = {pro_q, lang_q, port_q, link_sel_q};
					pw_d = pw_q; pw_len_d = pw_len_q;
				end
				echo_d = suf_d != SUF_PASSWD;
				ev[EV_OK]    = suf_d == SUF_OK;
				ev[EV_ERR]   = suf_d == SUF_UNKNOWN || suf_d == SUF_PARAM;
				ev[EV_BADPW] = suf_d == SUF_PASSWD;
			end
			ST_SEND: if (!tx_valid_q || tx_ready) begin
				tx_valid_d = 1'b1;
				unique case (ph_q)
					PH_ECHO: begin
						if (echo_q && idx_q < len_q) begin
							tx_data_d = buf_q[idx_q[5:0]]; idx_d = 7'(idx_q + 7'h01);
						end else begin
							tx_valid_d = 1'b0; ph_d = PH_PAY; idx_d = 7'h00;
						end
					end
					PH_PAY: begin
						unique case (pay_q)
							PAY_NONE: begin
								tx_valid_d = 1'b0; ph_d = PH_SUF; idx_d = 7'h00;
							end
							PAY_DIGIT: begin
								tx_data_d = pre_v_q ? pre_q : digit_q;
								pre_v_d = 1'b0;
								if (!pre_v_q) pay_d = PAY_NONE;
							end
							PAY_PORT: begin
								// pre_v marks a digit already sent
								tx_valid_d = port_dig != 4'h0 || pre_v_q || idx_q == 7'h04;
								tx_data_d = 8'(CH_ZERO + 8'(port_dig));
								pre_v_d = pre_v_q || tx_valid_d;
								idx_d = 7'(idx_q + 7'h01);
								if (idx_q == 7'h04) pay_d = PAY_NONE;
							end
							default: begin
								if (pre_v_q) begin
									tx_data_d = pre_q; pre_v_d = 1'b0;
								end else if (info_char != 8'h00 && idx_q < 7'(INFO_MAX)) begin
									tx_data_d = info_char; idx_d = 7'(idx_q + 7'h01);
								end else begin
									tx_valid_d = 1'b0; idx_d = 7'h00;
									pre_d = CH_COMMA; pre_v_d = 1'b1;
									if (fld_q != ((tgt_q == 3'h0) ? CO_FIELDS : CH_FIELDS) - 3'h1)
										fld_d = 3'(fld_q + 3'h1);
									else if (tgt_q == 3'h0) begin
										pay_d = PAY_NONE; pre_v_d = 1'b0;
									end else begin
										pay_d = PAY_DIGIT;
										digit_d = chan_present[2'(tgt_q - 3'h1)] ? 8'h31 : 8'h30;
									end
								end
							end
						endcase
					end
					PH_SUF: begin
						tx_data_d = msg_char(suf_q, idx_q);
						idx_d = 7'(idx_q + 7'h01);
						if (idx_q == msg_len(suf_q) - 7'h01) ph_d = PH_CR;
					end
					PH_CR: begin
						tx_data_d = CH_CR; ph_d = PH_LF;
					end
					default: begin
						tx_data_d = CH_LF; st_d = ST_IDLE;
					end
				endcase
			end
			default: st_d = ST_IDLE;
		endcase
		// bus write takes effect at the edge where ack is seen, except a config write during evaluation or below 1024
		ist_d = ist_q;
		if (wb_req.cyc && wb_req.stb && ack_q && wb_req.we && wb_req.sel[0]) begin
			unique case (wb_req.adr[7:2])
				REG_IRQ_STAT: ist_d = ist_q & ~wb_req.dat[EV_W-1:0];
				REG_IRQ_MASK: imask_d = wb_req.dat[EV_W-1:0];
				default: ;
			endcase
		end
		if (wb_req.cyc && wb_req.stb && ack_q && wb_req.we && wb_req.adr[7:2] == REG_CONFIG
			&& st_q != ST_EVAL) begin
			if (wport >= PORT_MIN) port_d = wport[15:0];
		end
		ist_d = ist_d | ev;
		if (wb_req.cyc && wb_req.stb && !ack_q) begin
			unique case (wb_req.adr[7:2])
				REG_CONFIG:   rdat_d = {16'h0000, port_q};
				REG_STATUS: begin
					rdat_d[STS_LINK_SEL]      = link_sel_q;
					rdat_d[STS_LINK_ACT]      = link_act_q;
					rdat_d[STS_PRO]           = pro_q;
					rdat_d[STS_LANG +: 2]     = lang_q;
					rdat_d[STS_SEL_AUTO]      = sel_s2_q;
					rdat_d[STS_BUSY]          = st_q != ST_IDLE;
				end
				REG_IRQ_STAT: rdat_d[EV_W-1:0] = ist_q;
				REG_IRQ_MASK: rdat_d[EV_W-1:0] = imask_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		sel_s1_q <= selector_auto_position;
		sel_s2_q <= sel_s1_q;
		if (srst) begin
			st_q <= ST_IDLE; ph_q <= PH_ECHO; suf_q <= SUF_OK; pay_q <= PAY_NONE;
			buf_q <= '{default: 8'h00}; len_q <= 7'h00; ovf_q <= 1'b0; tmo_q <= '0;
			idx_q <= 7'h00; echo_q <= 1'b0; digit_q <= 8'h00; pre_q <= 8'h00;
			pre_v_q <= 1'b0; tgt_q <= 3'h0; fld_q <= 3'h0;
			tx_data_q <= 8'h00; tx_valid_q <= 1'b0;
			port_q <= PORT_RST; link_sel_q <= 1'b0; link_boot_q <= 1'b0; boot_q <= 1'b0;
			link_act_q <= 1'b0; pro_q <= 1'b0; lang_q <= 2'h0;
			pw_q <= '{default: 8'h00}; pw_len_q <= 5'h00;
			ist_q <= '0; imask_q <= '0; ack_q <= 1'b0; rdat_q <= 32'h00000000;
		end else begin
			st_q <= st_d; ph_q <= ph_d; suf_q <= suf_d; pay_q <= pay_d;
			buf_q <= buf_d; len_q <= len_d; ovf_q <= ovf_d; tmo_q <= tmo_d;
			idx_q <= idx_d; echo_q <= echo_d; digit_q <= digit_d; pre_q <= pre_d;
			pre_v_q <= pre_v_d; tgt_q <= tgt_d; fld_q <= fld_d;
			tx_data_q <= tx_data_d; tx_valid_q <= tx_valid_d;
			port_q <= port_d; link_sel_q <= link_sel_d; link_boot_q <= link_boot_d;
			boot_q <= boot_d; link_act_q <= link_act_d; pro_q <= pro_d; lang_q <= lang_d;
			pw_q <= pw_d; pw_len_q <= pw_len_d;
			ist_q <= ist_d; imask_q <= imask_d; ack_q <= ack_d; rdat_q <= rdat_d;
		end
	end

	// input stays closed until the last reply byte is taken
	assign rx_ready     = (st_q == ST_IDLE && !tx_valid_q) || st_q == ST_RECV;
	assign tx_data      = tx_data_q;
	assign tx_valid     = tx_valid_q;
	assign wb_rsp       = '{ack: ack_q, dat: rdat_q};
	assign link_store   = link_sel_q;
	assign link_active  = link_act_q;
	assign data_port    = port_q;
	assign access_pro   = pro_q;
	assign web_language = lang_q;
	assign info_target  = tgt_q;
	assign info_field   = fld_q;
	assign info_index   = idx_q[3:0];
	assign irq          = |(ist_q & imask_q);

endmodule : ascp_parser

// ==== verification/ascp_parser_assertions.sv ====
`timescale 1ns/1ps
module ascp_parser_assertions (
	input wire logic                   clk_sys,
	input wire logic                   srst,
	input wire ascp_pkg::ascp_wb_req_s wb_req,
	input wire ascp_pkg::ascp_wb_rsp_s wb_rsp,
	input wire logic                   rx_ready,
	input wire logic [7:0]             tx_data,
	input wire logic                   tx_valid,
	input wire logic                   tx_ready,
	input wire logic                   selector_auto_position,
	input wire logic                   link_active,
	input wire logic [15:0]            data_port,
	input wire logic                   access_pro,
	input wire logic [1:0]             web_language
);
	import ascp_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	a_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
		else $error("bus request not answered next cycle");
	a_ack_drop: assert property (wb_rsp.ack |=> !wb_rsp.ack)
		else $error("ack longer than one cycle");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte not held");
	a_rx_closed: assert property (tx_valid |-> !rx_ready)
		else $error("input open while replying");
	a_port_range: assert property (data_port >= 16'h0400)
		else $error("data port below range");
	a_eth_only: assert property (!selector_auto_position [*4] |=> !link_active)
		else $error("fieldbus active outside auto position");
	a_lang_code: assert property (web_language != 2'h3)
		else $error("language code out of range");
	a_level_eval: assert property ($changed(access_pro) |-> !rx_ready)
		else $error("access level changed outside evaluation");
	cover property (wb_rsp.ack);
	cover property (tx_valid && !tx_ready);
	cover property ($rose(access_pro));
endmodule : ascp_parser_assertions

bind ascp_parser ascp_parser_assertions i_chk (.clk_sys, .srst, .wb_req, .wb_rsp, .rx_ready,
	.tx_data, .tx_valid, .tx_ready, .selector_auto_position, .link_active, .data_port,
	.access_pro, .web_language);

// ==== verification/ascp_host_model.sv ====
`timescale 1ns/1ps
module ascp_host_model (
	input  wire logic clk_sys,
	input  wire logic rx_ready,
	output logic [7:0] rx_data,
	output logic      rx_valid,
	output logic      tx_ready
);
	int seed = 32'hc36d;
	int late = 0;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// stall the reply side at random
	always @(posedge clk_sys) begin
		tx_ready <= ($random(seed) & 3) != 0;
	end
	task send(input string s);
		int n;
		for (int i = 0; i < s.len(); i++) begin
			rx_valid <= 1'b1;
			rx_data <= s[i];
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (rx_ready !== 1'b1 && n < 500);
			if (n >= 500)
				late++;
		end
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask : send
endmodule : ascp_host_model

// ==== verification/ascp_parser_tb_top.sv ====
`timescale 1ns/1ps
module ascp_parser_tb_top;
	import ascp_pkg::*;
	logic clk_sys = 1'b0, srst = 1'b1, sel_auto = 1'b1, link_nv = 1'b0;
	ascp_wb_req_s wb_req = '0;
	ascp_wb_rsp_s wb_rsp;
	logic [7:0] rx_data, tx_data, info_char, exp_q[$];
	logic rx_valid, rx_ready, tx_valid, tx_ready, link_store, link_active, access_pro, irq;
	logic [15:0] data_port;
	logic [1:0] web_language;
	logic [2:0] info_field, info_target;
	logic [3:0] info_index;
	logic [31:0] rd;
	int fails = 0, cmp_count = 0, seed = 32'hc36d, p, n;
	always #20 clk_sys = ~clk_sys;
	// one letter per field, picked by the field number
	assign info_char = (info_index == 4'h0) ? 8'h41 + {5'h00, info_field} : 8'h00;
	ascp_parser #(.TIMEOUT_CYCLES(200)) i_dut (.clk_sys, .srst, .wb_req, .wb_rsp, .rx_data,
		.rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready, .selector_auto_position(sel_auto),
		.link_nv, .link_store, .link_active, .data_port, .access_pro, .web_language,
		.chan_present(4'h5), .info_target, .info_field, .info_index, .info_char, .irq);
	ascp_host_model i_host (.clk_sys, .rx_ready, .rx_data, .rx_valid, .tx_ready);
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task results;
		fails = fails + i_host.late;
		if (fails == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	always @(posedge clk_sys) begin
		if (!srst && tx_valid === 1'b1 && tx_ready === 1'b1)
			chk({24'h0, tx_data}, exp_q.size() ? {24'h0, exp_q.pop_front()} : 32'h100);
	end
	task do_reset;
		link_nv <= (link_store === 1'b1);
		srst <= 1'b1;
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
	endtask : do_reset
	task cmd(input string c, input string r, input bit e = 1);
		string x;
		x = {e ? c : "", r, "\015\012"};
		for (int i = 0; i < x.len(); i++)
			exp_q.push_back(x[i]);
		i_host.send(r == "$TIMEOUT" ? c : {c, "\015"});
		for (n = 0; n < 3000 && exp_q.size() != 0; n++)
			@(posedge clk_sys);
		if (n == 3000) begin
			fails++;
			results();
		end
		repeat (2) @(posedge clk_sys);
	endtask : cmd
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 20);
		rd = wb_rsp.dat;
		wb_req <= '0;
		@(posedge clk_sys);
		if (n >= 20) begin
			fails++;
			results();
		end
	endtask : wb
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		cmd($sformatf("$%s1", CMD_LINK), "OK");
		chk(32'(link_active), 32'h0);
		chk(32'(link_store), 32'h1);
		cmd($sformatf("$%s?", CMD_LINK), "1OK");
		do_reset();
		repeat (4) @(posedge clk_sys);
		chk(32'(link_active), 32'h1);
		sel_auto <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk(32'(link_active), 32'h0);
		sel_auto <= 1'b1;
		cmd($sformatf("$%s0", CMD_LINK), "OK");
		cmd($sformatf("$%s", CMD_DPQ), "10001OK");
		p = 1024 + ({$random(seed)} % 64512);
		cmd($sformatf("$%s%0d", CMD_DPS, p), "OK");
		cmd($sformatf("$%s1023", CMD_DPS), "$WRONG PARAMETER");
		chk(32'(data_port), p);
		for (int k = 0; k < 3; k++) begin
			cmd($sformatf("$%s%0d", CMD_LANG, k), "OK");
			chk(32'(web_language), k);
		end
		cmd($sformatf("$%s3", CMD_LANG), "$WRONG PARAMETER");
		cmd("$ABC", "$UNKNOWN COMMAND");
		cmd($sformatf("$%s", CMD_LOGIN), "OK");
		chk(32'(access_pro), 32'h1);
		cmd($sformatf("$%s", CMD_LOGO), "OK");
		chk(32'(access_pro), 32'h0);
		cmd($sformatf("$%s,ab1,ab1", CMD_PWCH), "OK");
		cmd($sformatf("$%sab1,a-b,a-b", CMD_PWCH), "$WRONG PARAMETER");
		cmd($sformatf("$%szz,q,q", CMD_PWCH), "$WRONG PASSWORD", 0);
		cmd($sformatf("$%s", CMD_LOGIN), "$WRONG PASSWORD", 0);
		chk(32'(access_pro), 32'h0);
		cmd($sformatf("$%sab1", CMD_LOGIN), "OK");
		cmd($sformatf("$%s1", CMD_CHAN), ":A,B,C,D,E,F,1OK");
		cmd($sformatf("$%s2", CMD_CHAN), ":A,B,C,D,E,F,0OK");
		chk(32'(info_target), 32'h2);
		cmd($sformatf("$%s5", CMD_CHAN), "$WRONG PARAMETER");
		cmd($sformatf("$%s", CMD_CTRL), "A,B,C,D,EOK");
		cmd("$LG", "$TIMEOUT");
		wb(1'b1, 8'h08, 32'hF);
		wb(1'b1, 8'h0C, 32'h1);
		cmd($sformatf("$%s", CMD_LOGO), "OK");
		chk(32'(irq), 32'h1);
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h1);
		wb(1'b1, 8'h08, 32'h1);
		chk(32'(irq), 32'h0);
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h32);
		wb(1'b1, 8'h00, 32'd1023);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, p);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		results();
	end
endmodule : ascp_parser_tb_top
